// ---- design/lpdc_defs.svh ----
// lpdc_defs.svh: offsets, field positions, reset values and counts
// for the low-power domain controller; assumes a 32-bit apb slave
// Behaviour
// - always-on core domain stays powered; no force override exists
// - per-domain software force up and force down, independent
// - peripheral domain on in active states, off in deep sleep
// - core domain off forces every nested domain off
// - each main sram bank has its own power gate
// - controller sequences sleep entry/exit and drives gating signals
// - eight always-on 32-bit retention registers
// - reset selects 8 MHz oscillator fast and rc oscillator slow
// - offers 8 MHz oscillator divided by 256 as clock source
// - digital sleep clock selector among four sources
// - power-up pin high keeps always-on regulator on
// - 3-bit always-on voltage trim driven in normal work
// - flash regulator output enabled by its enable bit
// - tie-high bit picks 3.3V input or reference regulation
// - supply-low flag follows comparator and sheds power-hungry blocks
// - 3-bit supply-low threshold selects comparator level
// - modem sleep keeps cpu clocked, turns baseband and radio off
// - light sleep gates core clock, stalls cpu, stops clocks, radio
// - deep sleep powers core down, keeps retention registers
// - active mode after reset
// - per-source wake mask bits select wake sources, any combination
`ifndef LPDC_DEFS_SVH
`define LPDC_DEFS_SVH

`define LPDC_OFF_CTRL     12'h000
`define LPDC_OFF_FPU      12'h004
`define LPDC_OFF_FPD      12'h008
`define LPDC_OFF_CLKSEL   12'h00C
`define LPDC_OFF_VREG     12'h010
`define LPDC_OFF_WAKE     12'h014
`define LPDC_OFF_STATUS   12'h018
`define LPDC_OFF_SRAMPD   12'h01C
`define LPDC_OFF_RET0     12'h020
`define LPDC_OFF_RET7     12'h03C

// domain indices of the force masks
`define LPDC_NDOM         11
`define LPDC_D_PERIPH     0
`define LPDC_D_SLOWMEM    1
`define LPDC_D_FASTMEM    2
`define LPDC_D_CORE       3
`define LPDC_D_BBAND      4
`define LPDC_D_ROM        5
`define LPDC_D_SRAM       6
`define LPDC_D_XTAL       7
`define LPDC_D_PLL        8
`define LPDC_D_OSC8M      9
`define LPDC_D_RADIO      10

`define LPDC_NWAKE        11
`define LPDC_NBANK        4
`define LPDC_NRET         8
`define LPDC_DIV_N        256

// control fields
`define LPDC_CTRL_GO      4
`define LPDC_CLK_FAST     0
`define LPDC_CLK_SLOW_LO  1
`define LPDC_CLK_DIG_LO   4
`define LPDC_CLKSEL_RST   32'h0000_0000
`define LPDC_VREG_RST     32'h0004_2A14
`define LPDC_WAKE_RST     32'h0000_0008
`define LPDC_ST_LOW       4
`define LPDC_ST_CAUSE_LO  16

`endif

// ---- design/lpdc_pkg.sv ----
// lpdc_pkg.sv: types shared by the low-power domain controller
// assumes lpdc_defs.svh for numeric constants
package lpdc_pkg;

    typedef enum logic [1:0] {
        ST_ACTIVE,
        ST_MODEM,
        ST_LIGHT,
        ST_DEEP
    } lpdc_mode_t;

    typedef struct packed {
        logic [2:0] aon_trim;
        logic       flash_en;
        logic       flash_tieh;
        logic [1:0] vref_hi;
        logic [1:0] vref_mid;
        logic [1:0] vref_lo;
        logic [2:0] low_thres;
    } lpdc_vreg_t;

    typedef struct packed {
        logic       reg_on;
        logic       reg_deep;
        logic       core_clk_en;
        logic       cpu_stall;
        logic       hungry_off;
    } lpdc_ctl_t;

endpackage

// ---- design/lpdc_ctrl.sv ----
// lpdc_ctrl.sv: always-on power, clock and regulator control with apb
// assumes a single 25 MHz clock standing for the 8 MHz oscillator tap;
// pins and comparator outputs arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "lpdc_defs.svh"

module lpdc_ctrl #(
    parameter int NDOM  = `LPDC_NDOM,
    parameter int NWAKE = `LPDC_NWAKE,
    parameter int NBANK = `LPDC_NBANK,
    parameter int NRET  = `LPDC_NRET
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_resetn,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    input  wire logic               i_chip_power_up_pin,
    input  wire logic               i_supply_low,
    input  wire logic [NWAKE-1:0]   i_wake_src,
    output logic                    o_aon_core_pwr,
    output logic      [NDOM-1:0]    o_dom_pwr,
    output logic      [NBANK-1:0]   o_sram_bank_pwr,
    output logic                    o_fast_clk_sel,
    output logic      [1:0]         o_slow_clk_sel,
    output logic      [1:0]         o_dig_slp_clk_sel,
    output logic                    o_div256_tick,
    output lpdc_pkg::lpdc_vreg_t    o_vreg,
    output lpdc_pkg::lpdc_ctl_t     o_ctl,
    output logic                    o_supply_low_flag
);

    typedef struct packed {
        logic [1:0]             pu_sync;
        logic [1:0]             low_sync;
        logic [NWAKE-1:0]       wk_s1;
        logic [NWAKE-1:0]       wk_s2;
        lpdc_pkg::lpdc_mode_t   mode;
        logic [1:0]             req_mode;
        logic [NDOM-1:0]        force_power_up;
        logic [NDOM-1:0]        force_power_down;
        logic [NBANK-1:0]       bank_off;
        logic [5:0]             clksel;
        lpdc_pkg::lpdc_vreg_t   vreg;
        logic [NWAKE-1:0]       wake_mask;
        logic [NWAKE-1:0]       wake_cause;
        logic                   low_seen;
        logic [7:0]             div_cnt;
        logic                   div_tick;
        logic [NRET-1:0][31:0]  ret;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic [NDOM-1:0]        dom_pwr;
        logic [NBANK-1:0]       bank_pwr;
        lpdc_pkg::lpdc_ctl_t    ctl;
    } lpdc_state_t;

    lpdc_state_t st_reg;
    lpdc_state_t st_next;
    logic [NDOM-1:0] base_on;
    logic [NDOM-1:0] dom_want;

    // state-derived power by mode, one column per main state
    always_comb begin
        base_on = '1;
        case (st_reg.mode)
            lpdc_pkg::ST_ACTIVE: begin
                base_on = '1;
            end
            lpdc_pkg::ST_MODEM: begin
                base_on[`LPDC_D_BBAND] = 1'b0;
                base_on[`LPDC_D_RADIO] = 1'b0;
            end
            lpdc_pkg::ST_LIGHT: begin
                base_on[`LPDC_D_SLOWMEM] = 1'b0;
                base_on[`LPDC_D_FASTMEM] = 1'b0;
                base_on[`LPDC_D_BBAND] = 1'b0;
                base_on[`LPDC_D_XTAL]  = 1'b0;
                base_on[`LPDC_D_PLL]   = 1'b0;
                base_on[`LPDC_D_OSC8M] = 1'b0;
                base_on[`LPDC_D_RADIO] = 1'b0;
            end
            lpdc_pkg::ST_DEEP: begin
                // memories stay only if forced up
                base_on = '0;
            end
            default: begin
                base_on = '1;
            end
        endcase
    end

    // per-domain override: force down first, then force up
    genvar d;
    generate
        for (d = 0; d < NDOM; d++) begin : g_dom
            assign dom_want[d] = st_reg.force_power_down[d] ? 1'b0 :
                                 st_reg.force_power_up[d] ? 1'b1 :
                                 base_on[d];
        end
    endgenerate

    logic        acc;
    logic        setup;
    logic        mapped;
    logic [31:0] rd;
    logic [2:0]  ret_idx;
    logic        is_ret;
    logic [NWAKE-1:0] wk_hit;

    assign setup  = i_psel & ~i_penable;
    assign acc    = i_psel & i_penable & st_reg.pready;
    assign is_ret = (i_paddr >= `LPDC_OFF_RET0) &&
                    (i_paddr <= `LPDC_OFF_RET7) &&
                    (i_paddr[1:0] == 2'b00);
    assign ret_idx = i_paddr[4:2];
    assign wk_hit  = st_reg.wk_s2 & st_reg.wake_mask;

    // read mux and address decode, evaluated in the setup cycle
    always_comb begin
        rd     = 32'h0000_0000;
        mapped = 1'b1;
        case (i_paddr)
            `LPDC_OFF_CTRL: begin
                rd[1:0] = st_reg.req_mode;
            end
            `LPDC_OFF_FPU: begin
                rd[NDOM-1:0] = st_reg.force_power_up;
            end
            `LPDC_OFF_FPD: begin
                rd[NDOM-1:0] = st_reg.force_power_down;
            end
            `LPDC_OFF_CLKSEL: begin
                rd[5:0] = st_reg.clksel;
            end
            `LPDC_OFF_VREG: begin
                rd[2:0]   = st_reg.vreg.aon_trim;
                rd[4]     = st_reg.vreg.flash_en;
                rd[5]     = st_reg.vreg.flash_tieh;
                rd[9:8]   = st_reg.vreg.vref_hi;
                rd[11:10] = st_reg.vreg.vref_mid;
                rd[13:12] = st_reg.vreg.vref_lo;
                rd[18:16] = st_reg.vreg.low_thres;
            end
            `LPDC_OFF_WAKE: begin
                rd[NWAKE-1:0] = st_reg.wake_mask;
            end
            `LPDC_OFF_STATUS: begin
                rd[1:0] = st_reg.mode;
                rd[`LPDC_ST_LOW] = st_reg.low_seen;
                rd[5] = st_reg.low_sync[1];
                rd[`LPDC_ST_CAUSE_LO +: NWAKE] = st_reg.wake_cause;
            end
            `LPDC_OFF_SRAMPD: begin
                rd[NBANK-1:0] = st_reg.bank_off;
            end
            default: begin
                if (is_ret) begin
                    rd = st_reg.ret[ret_idx];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // only the second stage of each synchroniser is consumed
        st_next.pu_sync  = {st_reg.pu_sync[0], i_chip_power_up_pin};
        st_next.low_sync = {st_reg.low_sync[0], i_supply_low};
        st_next.wk_s1    = i_wake_src;
        st_next.wk_s2    = st_reg.wk_s1;

        // free-running divide-by-256 tick of the oscillator clock
        st_next.div_cnt  = st_reg.div_cnt + 8'h01;
        st_next.div_tick = (st_reg.div_cnt == 8'(`LPDC_DIV_N - 1));

        // apb: no wait state; pready and read data come from flops loaded in setup
        st_next.pready  = setup;
        st_next.pslverr = setup & ~mapped;
        if (setup) begin
            st_next.prdata = mapped ? rd : 32'h0000_0000;
        end

        if (acc && i_pwrite && mapped) begin
            case (i_paddr)
                `LPDC_OFF_CTRL: begin
                    st_next.req_mode = i_pwdata[1:0];
                    // go moves the main state to the requested mode
                    if (i_pwdata[`LPDC_CTRL_GO]) begin
                        st_next.mode =
                            lpdc_pkg::lpdc_mode_t'(i_pwdata[1:0]);
                    end
                end
                `LPDC_OFF_FPU: begin
                    st_next.force_power_up = i_pwdata[NDOM-1:0];
                end
                `LPDC_OFF_FPD: begin
                    st_next.force_power_down = i_pwdata[NDOM-1:0];
                end
                `LPDC_OFF_CLKSEL: begin
                    st_next.clksel = i_pwdata[5:0];
                end
                `LPDC_OFF_VREG: begin
                    st_next.vreg.aon_trim   = i_pwdata[2:0];
                    st_next.vreg.flash_en   = i_pwdata[4];
                    st_next.vreg.flash_tieh = i_pwdata[5];
                    st_next.vreg.vref_hi    = i_pwdata[9:8];
                    st_next.vreg.vref_mid   = i_pwdata[11:10];
                    st_next.vreg.vref_lo    = i_pwdata[13:12];
                    st_next.vreg.low_thres  = i_pwdata[18:16];
                end
                `LPDC_OFF_WAKE: begin
                    st_next.wake_mask = i_pwdata[NWAKE-1:0];
                end
                `LPDC_OFF_STATUS: begin
                    // write one to clear the sticky bits
                    if (i_pwdata[`LPDC_ST_LOW]) begin
                        st_next.low_seen = 1'b0;
                    end
                    st_next.wake_cause = st_reg.wake_cause &
                        ~i_pwdata[`LPDC_ST_CAUSE_LO +: NWAKE];
                end
                `LPDC_OFF_SRAMPD: begin
                    st_next.bank_off = i_pwdata[NBANK-1:0];
                end
                default: begin
                    if (is_ret) begin
                        st_next.ret[ret_idx] = i_pwdata;
                    end
                end
            endcase
        end

        // sticky events set after the clears so a same-cycle set wins
        if (st_reg.low_sync[1]) begin
            st_next.low_seen = 1'b1;
        end
        if (st_reg.mode != lpdc_pkg::ST_ACTIVE && |wk_hit) begin
            st_next.mode = lpdc_pkg::ST_ACTIVE;
            st_next.wake_cause = st_next.wake_cause | wk_hit;
        end

        // nested domains follow the core domain down
        st_next.dom_pwr = dom_want;
        if (!dom_want[`LPDC_D_CORE]) begin
            st_next.dom_pwr[`LPDC_D_BBAND] = 1'b0;
            st_next.dom_pwr[`LPDC_D_ROM]   = 1'b0;
            st_next.dom_pwr[`LPDC_D_SRAM]  = 1'b0;
        end
        // a bank is on only while the sram domain itself is on
        st_next.bank_pwr = st_next.dom_pwr[`LPDC_D_SRAM] ?
                           ~st_reg.bank_off : '0;

        // regulator may only be turned off with the power-up pin low
        st_next.ctl.reg_on   = st_reg.pu_sync[1] |
                               (st_reg.mode != lpdc_pkg::ST_DEEP);
        st_next.ctl.reg_deep = (st_reg.mode == lpdc_pkg::ST_DEEP);
        st_next.ctl.core_clk_en = (st_reg.mode == lpdc_pkg::ST_ACTIVE) ||
                                  (st_reg.mode == lpdc_pkg::ST_MODEM);
        st_next.ctl.cpu_stall = (st_reg.mode == lpdc_pkg::ST_LIGHT);
        st_next.ctl.hungry_off = st_reg.low_sync[1];
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg            <= '0;
            st_reg.mode       <= lpdc_pkg::ST_ACTIVE;
            st_reg.clksel     <= 6'(`LPDC_CLKSEL_RST);
            // register layout differs from the struct: unpack field by field
            st_reg.vreg.aon_trim   <= 3'(`LPDC_VREG_RST);
            st_reg.vreg.flash_en   <= 1'(`LPDC_VREG_RST >> 4);
            st_reg.vreg.flash_tieh <= 1'(`LPDC_VREG_RST >> 5);
            st_reg.vreg.vref_hi    <= 2'(`LPDC_VREG_RST >> 8);
            st_reg.vreg.vref_mid   <= 2'(`LPDC_VREG_RST >> 10);
            st_reg.vreg.vref_lo    <= 2'(`LPDC_VREG_RST >> 12);
            st_reg.vreg.low_thres  <= 3'(`LPDC_VREG_RST >> 16);
            st_reg.wake_mask  <= NWAKE'(`LPDC_WAKE_RST);
            st_reg.dom_pwr    <= '1;
            st_reg.bank_pwr   <= '1;
            st_reg.ctl        <= 5'b1_0_1_0_0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_aon_core_pwr    = 1'b1;
    assign o_dom_pwr         = st_reg.dom_pwr;
    assign o_sram_bank_pwr   = st_reg.bank_pwr;
    assign o_fast_clk_sel    = st_reg.clksel[`LPDC_CLK_FAST];
    assign o_slow_clk_sel    = st_reg.clksel[`LPDC_CLK_SLOW_LO +: 2];
    assign o_dig_slp_clk_sel = st_reg.clksel[`LPDC_CLK_DIG_LO +: 2];
    assign o_div256_tick     = st_reg.div_tick;
    // trim reaches the regulator, which ignores it in deep sleep
    assign o_vreg            = st_reg.vreg;
    assign o_ctl             = st_reg.ctl;
    assign o_supply_low_flag = st_reg.low_sync[1];
    assign o_prdata          = st_reg.prdata;
    assign o_pready          = st_reg.pready;
    assign o_pslverr         = st_reg.pslverr;

endmodule
`default_nettype wire

// ---- test/lpdc_ctrl_props.sv ----
// lpdc_ctrl_props.sv: concurrent checks on the controller's ports
// assumes apb writes land at the edge with psel, penable, pready high
`timescale 1ns/1ps
`default_nettype none
`include "lpdc_defs.svh"
module lpdc_props #(
    parameter int NDOM  = `LPDC_NDOM,
    parameter int NWAKE = `LPDC_NWAKE,
    parameter int NBANK = `LPDC_NBANK,
    parameter int NRET  = `LPDC_NRET
) (
    input wire logic                 i_clk_sys,
    input wire logic                 i_resetn,
    input wire logic                 i_psel,
    input wire logic                 i_penable,
    input wire logic                 i_pwrite,
    input wire logic [11:0]          i_paddr,
    input wire logic [31:0]          i_pwdata,
    input wire logic [31:0]          o_prdata,
    input wire logic                 o_pready,
    input wire logic                 o_pslverr,
    input wire logic                 i_chip_power_up_pin,
    input wire logic                 i_supply_low,
    input wire logic [NWAKE-1:0]     i_wake_src,
    input wire logic                 o_aon_core_pwr,
    input wire logic [NDOM-1:0]      o_dom_pwr,
    input wire logic [NBANK-1:0]     o_sram_bank_pwr,
    input wire logic                 o_fast_clk_sel,
    input wire logic [1:0]           o_slow_clk_sel,
    input wire logic [1:0]           o_dig_slp_clk_sel,
    input wire logic                 o_div256_tick,
    input wire lpdc_pkg::lpdc_vreg_t o_vreg,
    input wire lpdc_pkg::lpdc_ctl_t  o_ctl,
    input wire logic                 o_supply_low_flag
);
    logic [NDOM-1:0]  fpu_m, fpd_m, keep;
    logic [NBANK-1:0] bank_m;
    logic             wr_hit;
    // shadows of the force and bank masks, rebuilt from bus writes
    assign wr_hit = i_psel && i_penable && o_pready && i_pwrite;
    // nested domains cannot stay on while the core is off
    assign keep = o_dom_pwr[3] ? {NDOM{1'b1}} : ~(NDOM'(7) << 4);
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            fpu_m  <= '0;
            fpd_m  <= '0;
            bank_m <= '0;
        end else if (wr_hit) begin
            if (i_paddr == `LPDC_OFF_FPU) fpu_m <= i_pwdata[NDOM-1:0];
            if (i_paddr == `LPDC_OFF_FPD) fpd_m <= i_pwdata[NDOM-1:0];
            if (i_paddr == `LPDC_OFF_SRAMPD) bank_m <= i_pwdata[NBANK-1:0];
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_low_held; i_supply_low [*6]; endsequence
    sequence s_high_held; !i_supply_low [*6]; endsequence
    sequence s_pin_held; i_chip_power_up_pin [*5]; endsequence
    property p_aon; o_aon_core_pwr; endproperty
    property p_nested;
        !o_dom_pwr[3] |-> o_dom_pwr[6:4] == 3'h0 && o_sram_bank_pwr == '0;
    endproperty
    property p_div;
        o_div256_tick |=> !o_div256_tick [*8] ##248 o_div256_tick;
    endproperty
    property p_pin; s_pin_held |-> o_ctl.reg_on; endproperty
    property p_low_on;
        s_low_held |-> o_supply_low_flag && o_ctl.hungry_off;
    endproperty
    property p_low_off; s_high_held |-> !o_supply_low_flag; endproperty
    property p_fpd; (o_dom_pwr & $past(fpd_m)) == '0; endproperty
    property p_fpu;
        (o_dom_pwr & $past(fpu_m) & ~$past(fpd_m) & keep)
            == ($past(fpu_m) & ~$past(fpd_m) & keep);
    endproperty
    property p_bank; (o_sram_bank_pwr & $past(bank_m)) == '0; endproperty
    property p_clk_rst;
        $rose(i_resetn) |-> !o_fast_clk_sel && o_slow_clk_sel == 2'h0;
    endproperty
    a_aon: assert property (p_aon)
        else $error("always-on core domain not powered");
    a_nested: assert property (p_nested)
        else $error("nested domain on while core is off");
    a_div: assert property (p_div)
        else $error("divide-by-256 tick spacing wrong");
    a_pin: assert property (p_pin)
        else $error("regulator off while power-up pin high");
    a_low_on: assert property (p_low_on)
        else $error("supply-low flag or shedding missing");
    a_low_off: assert property (p_low_off)
        else $error("supply-low flag stuck high");
    a_fpd: assert property (p_fpd)
        else $error("force-down domain still powered");
    a_fpu: assert property (p_fpu)
        else $error("force-up domain not powered");
    a_bank: assert property (p_bank)
        else $error("switched-off sram bank still powered");
    a_clk_rst: assert property (p_clk_rst)
        else $error("clock selects not at defaults after reset");
endmodule
bind lpdc_ctrl lpdc_props #(.NDOM(NDOM), .NWAKE(NWAKE), .NBANK(NBANK),
    .NRET(NRET)) props_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_chip_power_up_pin(i_chip_power_up_pin), .i_supply_low(i_supply_low),
    .i_wake_src(i_wake_src), .o_aon_core_pwr(o_aon_core_pwr),
    .o_dom_pwr(o_dom_pwr), .o_sram_bank_pwr(o_sram_bank_pwr),
    .o_fast_clk_sel(o_fast_clk_sel), .o_slow_clk_sel(o_slow_clk_sel),
    .o_dig_slp_clk_sel(o_dig_slp_clk_sel), .o_div256_tick(o_div256_tick),
    .o_vreg(o_vreg), .o_ctl(o_ctl), .o_supply_low_flag(o_supply_low_flag));
`default_nettype wire

// ---- test/low_power_domain_control_tb_top.sv ----
// low_power_domain_control_tb_top.sv: directed bench for lpdc_ctrl
// assumes a 25 MHz clock and the designer's apb register map
`timescale 1ns/1ps
`default_nettype none
`include "lpdc_defs.svh"
module low_power_domain_control_tb_top;
    logic                 clk = 1'b0, rstn = 1'b0;
    logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0000_0000;
    logic                 pin = 1'b1, low = 1'b0;
    logic [10:0]          wake = 11'h000;
    logic [31:0]          prdata, q, w;
    logic                 pready, pslverr, aon, fsel, tick, lowf, e;
    logic [10:0]          dom;
    logic [3:0]           bank;
    logic [1:0]           ssel, dsel;
    lpdc_pkg::lpdc_vreg_t vreg;
    lpdc_pkg::lpdc_ctl_t  ctl;
    int                   miscompares = 0, check_count = 0, n;

    always #20 clk = ~clk;

    lpdc_ctrl dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_chip_power_up_pin(pin),
        .i_supply_low(low), .i_wake_src(wake), .o_aon_core_pwr(aon),
        .o_dom_pwr(dom), .o_sram_bank_pwr(bank), .o_fast_clk_sel(fsel),
        .o_slow_clk_sel(ssel), .o_dig_slp_clk_sel(dsel),
        .o_div256_tick(tick), .o_vreg(vreg), .o_ctl(ctl),
        .o_supply_low_flag(lowf));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, x);
        check_count++;
        if (s !== x) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    // entered just after an edge; leaves one idle edge so the next
    // call never drives psel twice in one time step
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        err;
        apb(1'b1, a, d, r, err);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] m, x);
        logic [31:0] r;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, r, err);
        chk(nm, r & m, x);
    endtask

    task automatic mode(input logic [1:0] m);
        wr(`LPDC_OFF_CTRL, 32'h0000_0010 | 32'(m));
        cyc(3);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("aon", aon, 1);
        chk("dom rst", dom, 11'h7FF);
        chk("fast sel", fsel, 0);
        chk("slow sel", ssel, 0);
        rdc("mode rst", `LPDC_OFF_STATUS, 32'h3, 0);
        rdc("clk rst", `LPDC_OFF_CLKSEL, '1, `LPDC_CLKSEL_RST);
        rdc("wake rst", `LPDC_OFF_WAKE, '1, `LPDC_WAKE_RST);
        rdc("vreg rst", `LPDC_OFF_VREG, '1, `LPDC_VREG_RST);
        apb(1'b0, 12'h040, 32'h0000_0000, q, e);
        chk("unmapped err", e, 1);
        chk("unmapped data", q, 0);
        for (int i = 0; i < 8; i++)
            wr(`LPDC_OFF_RET0 + 12'(4 * i), 32'hA5A5_0000 | i);
        n = 0;
        repeat (512) begin
            @(posedge clk);
            if (tick === 1'b1) n++;
        end
        chk("ticks", n, 2);
        for (int i = 0; i < 4; i++) begin
            wr(`LPDC_OFF_CLKSEL, 32'((i << 4) | (i << 1) | (i & 1)));
            cyc(2);
            chk("dig sel", dsel, i);
            chk("slow sel", ssel, i);
            chk("fast sel", fsel, i & 1);
        end
        // trims keep their default vref fields throughout
        for (int i = 0; i < 8; i++) begin
            w = 32'h0000_2A00 | (i << 16) | ((i & 3) << 4) | i;
            wr(`LPDC_OFF_VREG, w);
            cyc(2);
            chk("vreg trim", vreg.aon_trim, i);
            chk("flash en", vreg.flash_en, i & 1);
            chk("flash tieh", vreg.flash_tieh, (i >> 1) & 1);
            chk("threshold", vreg.low_thres, i);
            chk("vref trims", vreg[8:3], 6'h2A);
        end
        wr(`LPDC_OFF_VREG, `LPDC_VREG_RST);
        wr(`LPDC_OFF_SRAMPD, 32'h0000_0005);
        cyc(2);
        chk("banks", bank, 4'hA);
        wr(`LPDC_OFF_SRAMPD, 32'h0000_0000);
        wr(`LPDC_OFF_FPD, 32'h0000_0001);
        cyc(2);
        chk("fpd periph", dom, 11'h7FE);
        wr(`LPDC_OFF_FPD, 32'h0000_0000);
        mode(2'h1);
        q = {ctl.core_clk_en, ctl.cpu_stall, dom[4], dom[10]};
        chk("modem", q, 4'h8);
        mode(2'h2);
        q = {ctl.core_clk_en, ctl.cpu_stall, dom[3], dom[10:7]};
        chk("light", q, 7'h30);
        mode(2'h0);
        chk("active periph", dom[0], 1);
        mode(2'h3);
        q = {ctl.reg_on, ctl.reg_deep, dom[3], dom[0]};
        chk("deep", q, 4'hC);
        wr(`LPDC_OFF_FPU, 32'h0000_0046);
        cyc(2);
        chk("deep forced", dom & 11'h046, 11'h006);
        wr(`LPDC_OFF_FPD, 32'h0000_0002);
        cyc(2);
        chk("fpd over fpu", dom[1], 0);
        wake <= 11'h001;
        cyc(6);
        rdc("masked off", `LPDC_OFF_STATUS, 32'h3, 32'h3);
        wake <= 11'h008;
        cyc(6);
        wake <= 11'h000;
        rdc("woken", `LPDC_OFF_STATUS, 32'h0008_0003, 32'h0008_0000);
        for (int i = 0; i < 8; i++) begin
            w = 32'hA5A5_0000 | i;
            rdc("retained", `LPDC_OFF_RET0 + 12'(4 * i), '1, w);
        end
        // a rewritten mask lets a different source end light sleep
        wr(`LPDC_OFF_WAKE, 32'h0000_0001);
        rdc("wake mask", `LPDC_OFF_WAKE, '1, 32'h0000_0001);
        mode(2'h2);
        rdc("light st", `LPDC_OFF_STATUS, 32'h3, 32'h2);
        wake <= 11'h001;
        cyc(6);
        wake <= 11'h000;
        rdc("src0 woken", `LPDC_OFF_STATUS, 32'h3, 0);
        wr(`LPDC_OFF_FPU, 32'h0000_0000);
        wr(`LPDC_OFF_FPD, 32'h0000_0000);
        low <= 1'b1;
        cyc(6);
        chk("low", {lowf, ctl.hungry_off}, 2'h3);
        rdc("low st", `LPDC_OFF_STATUS, 32'h30, 32'h30);
        low <= 1'b0;
        cyc(6);
        chk("low gone", lowf, 0);
        rdc("sticky", `LPDC_OFF_STATUS, 32'h30, 32'h10);
        wr(`LPDC_OFF_STATUS, 32'h0000_0010);
        rdc("cleared", `LPDC_OFF_STATUS, 32'h30, 0);
        conclude();
    end

    // the directed run needs roughly eight hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
